// ---- sep_pkg.sv ----
// Constants, types and field layout for the serial EEPROM port.
// Assumes a single 250 MHz clock domain for the register side.
package sep_pkg;
  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] SEP_CTRL_ADDR = 8'h90;
  localparam logic [2:0] SEP_CTL_RESET = 3'h7;
  localparam logic [4:0] SEP_UNUSED_RD = 5'h00;
  localparam logic [7:0] SEP_RD_ZERO   = 8'h00;

  // ******************************
  // Memory and serial framing
  // ******************************
  localparam int         SEP_MEM_BYTES  = 128;
  localparam int         SEP_PAGE_BYTES = 8;
  localparam logic [3:0] SEP_DEV_CODE   = 4'hA;  // Arbitrary value
  localparam logic [3:0] SEP_BITS_BYTE  = 4'h8;
  localparam logic [3:0] SEP_BIT_ACK    = 4'h8;
  localparam logic [3:0] SEP_BIT_END    = 4'h9;
  localparam logic [3:0] SEP_BIT_ONE    = 4'h1;
  localparam logic [2:0] SEP_LOW_ONE    = 3'h1;

  // ******************************
  // Timing
  // ******************************
  localparam longint SEP_CLK_MHZ  = 250;
  localparam longint SEP_WRITE_NS = 5000000;
  localparam int     SEP_WRITE_CYCLES = int'((SEP_WRITE_NS * SEP_CLK_MHZ + 999) / 1000);

  // ******************************
  // Types
  // ******************************
  typedef struct packed {
    logic eeprom_clock_bit;
    logic eeprom_data_bit;
    logic eeprom_power_bit;
  } sep_ctl_t;

  typedef enum logic [2:0] {
    SEP_IDLE   = 3'b000,
    SEP_CTRL   = 3'b001,
    SEP_ADDR   = 3'b010,
    SEP_DATA   = 3'b011,
    SEP_IGNORE = 3'b100
  } sep_state_t;
endpackage : sep_pkg

// ---- sep_top.sv ----
// Port control register at 90h and the on-chip two-wire EEPROM behind it.
// Assumes the bench resolves the open-drain data wire and returns both wire levels.
`timescale 1ns/1ps
`default_nettype none
module sep_top #(
  parameter int WRITE_CYCLES = sep_pkg::SEP_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // Processor register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Two-wire bus
  output var  logic       ee_scl_o,
  output var  logic       ee_scl_oe_n,
  output var  logic       ee_sda_o,
  output var  logic       ee_sda_oe_n,
  input  wire logic       ee_scl_i,
  input  wire logic       ee_sda_i,
  // Status
  output var  logic       ee_busy
);
  import sep_pkg::*;

  // ******************************
  // Port control register
  // ******************************
  sep_ctl_t   ctl_q;
  logic [7:0] rdata_q;
  logic       scl_o_q, scl_oe_n_q, sda_o_q, sda_oe_n_q;
  logic       ack_q, busy_q;

  wire        hit    = reg_addr == SEP_CTRL_ADDR;
  wire        pwr    = ctl_q.eeprom_power_bit;
  wire  [7:0] rd_val = pwr ? {SEP_UNUSED_RD, ctl_q} : SEP_RD_ZERO;
  wire        sda_lo = !ctl_q.eeprom_data_bit || ack_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_q   <= sep_ctl_t'(SEP_CTL_RESET);
      rdata_q <= SEP_RD_ZERO;
    end else if (ce) begin
      if (reg_wr && hit) ctl_q <= sep_ctl_t'(reg_wdata[2:0]);
      if (reg_rd) rdata_q <= hit ? rd_val : SEP_RD_ZERO;
    end
  end

  // Pin drivers: clock push-pull, data open-drain shared with the acknowledge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_o_q    <= 1'b1;
      scl_oe_n_q <= 1'b1;
      sda_o_q    <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (ce) begin
      scl_o_q    <= ctl_q.eeprom_clock_bit;
      scl_oe_n_q <= !pwr;
      sda_o_q    <= 1'b0;
      sda_oe_n_q <= !(pwr && sda_lo);
    end
  end

  assign reg_rdata   = rdata_q;
  assign ee_scl_o    = scl_o_q;
  assign ee_scl_oe_n = scl_oe_n_q;
  assign ee_sda_o    = sda_o_q;
  assign ee_sda_oe_n = sda_oe_n_q;
  assign ee_busy     = busy_q;

  // ******************************
  // Wire synchronisers
  // ******************************
  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_f_q, sda_f_q;

  wire scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  wire sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else if (ce) begin
      scl_s_q <= {scl_s_q[1:0], ee_scl_i};
      sda_s_q <= {sda_s_q[1:0], ee_sda_i};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  // ******************************
  // Serial receiver
  // ******************************
  sep_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [SEP_PAGE_BYTES-1:0] valid_q;
  logic [7:0] buf_q [SEP_PAGE_BYTES];
  logic [7:0] mem_q [SEP_MEM_BYTES];
  logic [31:0] wc_q;

  wire scl_rise  = scl_f_d && !scl_f_q;
  wire scl_fall  = !scl_f_d && scl_f_q;
  wire start     = scl_f_q && scl_f_d && sda_f_q && !sda_f_d;
  wire stop      = scl_f_q && scl_f_d && !sda_f_q && sda_f_d;
  wire ctrl_ok   = shift_q[7:4] == SEP_DEV_CODE && !shift_q[0] && !busy_q;
  wire ack_dec   = (state_q == SEP_CTRL) ? ctrl_ok
                 : (state_q == SEP_ADDR || state_q == SEP_DATA) && !busy_q;
  wire ack_begin = scl_fall && bit_q == SEP_BIT_ACK;
  wire byte_done = scl_fall && bit_q == SEP_BIT_END;
  wire commit    = pwr && stop && state_q == SEP_DATA && (|valid_q);
  wire wc_last   = wc_q == 32'(WRITE_CYCLES - 1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SEP_IDLE;
      bit_q   <= '0;
      shift_q <= '0;
      ack_q   <= 1'b0;
      ptr_q   <= '0;
    end else if (ce) begin
      if (!pwr || stop) begin
        state_q <= SEP_IDLE;
        bit_q   <= '0;
        ack_q   <= 1'b0;
      end else if (start) begin
        state_q <= SEP_CTRL;
        bit_q   <= '0;
        ack_q   <= 1'b0;
      end else if (scl_rise) begin
        if (bit_q < SEP_BITS_BYTE) shift_q <= {shift_q[6:0], sda_f_q};
        if (bit_q < SEP_BIT_END) bit_q <= bit_q + SEP_BIT_ONE;
      end else if (ack_begin) begin
        ack_q <= ack_dec;
      end else if (byte_done) begin
        ack_q <= 1'b0;
        bit_q <= '0;
        unique case (state_q)
          SEP_CTRL:   state_q <= ack_q ? SEP_ADDR : SEP_IGNORE;
          SEP_ADDR: begin
            state_q <= SEP_DATA;
            ptr_q   <= shift_q;
          end
          SEP_DATA:   ptr_q <= {ptr_q[7:3], ptr_q[2:0] + SEP_LOW_ONE};
          SEP_IDLE, SEP_IGNORE: state_q <= state_q;
          default:    state_q <= SEP_IDLE;
        endcase
      end
    end
  end

  // Page buffer: newest byte in a slot wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
    end else if (ce) begin
      if (start || !pwr) valid_q <= '0;
      else if (byte_done && state_q == SEP_DATA) valid_q[ptr_q[2:0]] <= 1'b1;
      else if (commit) valid_q <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && byte_done && state_q == SEP_DATA) buf_q[ptr_q[2:0]] <= shift_q;
  end

  // Commit buffered bytes into the page picked by the upper pointer bits
  always_ff @(posedge clock) begin
    if (ce && commit) begin
      for (int i = 0; i < SEP_PAGE_BYTES; i++) begin
        if (valid_q[i]) mem_q[{ptr_q[6:3], 3'(i)}] <= buf_q[i];
      end
    end
  end

  // ******************************
  // Self-timed write cycle
  // ******************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      wc_q   <= '0;
    end else if (ce) begin
      if (!pwr) begin
        busy_q <= 1'b0;
      end else if (commit) begin
        busy_q <= 1'b1;
        wc_q   <= '0;
      end else if (busy_q) begin
        if (wc_last) busy_q <= 1'b0;
        else wc_q <= wc_q + 32'h1;
      end
    end
  end

  // ******************************
  // Assertions
  // ******************************
  a_upper_zero: assert property (@(posedge clock) disable iff (rst)
    reg_rdata[7:3] == SEP_UNUSED_RD) else $error("upper bits not zero");
  a_off_readback: assert property (@(posedge clock) disable iff (rst)
    ce && reg_rd && hit && !pwr |=> reg_rdata == SEP_RD_ZERO) else $error("off readback");
  a_off_tristate: assert property (@(posedge clock) disable iff (rst)
    ce && !pwr |=> ee_sda_oe_n && ee_scl_oe_n) else $error("pins not released");
  a_data_low: assert property (@(posedge clock) disable iff (rst)
    ce && pwr && !ctl_q.eeprom_data_bit |=> !ee_sda_oe_n) else $error("data not low");
  a_reg_write: assert property (@(posedge clock) disable iff (rst)
    ce && reg_wr && hit |=> ctl_q == $past(reg_wdata[2:0])) else $error("write lost");
  a_busy_noack: assert property (@(posedge clock) disable iff (rst)
    busy_q && $past(busy_q) |-> !ack_q) else $error("ack while busy");
  a_stop_commit: assert property (@(posedge clock) disable iff (rst)
    ce && commit |=> busy_q && valid_q == '0) else $error("stop did not commit");
  a_addr_load: assert property (@(posedge clock) disable iff (rst)
    ce && byte_done && !start && !stop && pwr && state_q == SEP_ADDR
    |=> ptr_q == $past(shift_q) && state_q == SEP_DATA) else $error("address not loaded");
  a_page_wrap: assert property (@(posedge clock) disable iff (rst)
    ce && byte_done && !start && !stop && pwr && state_q == SEP_DATA
    |=> ptr_q[7:3] == $past(ptr_q[7:3]) && ptr_q[2:0] == $past(ptr_q[2:0]) + SEP_LOW_ONE)
    else $error("pointer step wrong");
  a_ctrl_ack: assert property (@(posedge clock) disable iff (rst)
    ce && ack_begin && !start && !stop && pwr && state_q == SEP_CTRL && ctrl_ok
    |=> ack_q ##1 !sda_oe_n_q) else $error("control byte not acked");
  a_mem_commit: assert property (@(posedge clock) disable iff (rst)
    ce && commit && valid_q[0] |=> mem_q[{ptr_q[6:3], 3'h0}] == $past(buf_q[0]))
    else $error("page byte not stored");

  c_write_cycle: cover property (@(posedge clock) disable iff (rst) commit ##1 busy_q);
  c_poll_nack: cover property (@(posedge clock) disable iff (rst)
    busy_q && ack_begin && state_q == SEP_CTRL);
  c_page_wrap: cover property (@(posedge clock) disable iff (rst)
    byte_done && state_q == SEP_DATA && ptr_q[2:0] == 3'h7);
endmodule : sep_top
`default_nettype wire

// ---- sep_bus_model.sv ----
// Far-side model of the two-wire bus: resolves the pins of the port into wire levels.
// Assumes a pull-up on the data line only; the clock line has no pull.
`timescale 1ns/1ps
`default_nettype none
module sep_bus_model (
  // Clock
  input  wire logic clock,
  // Pins from the port
  input  wire logic scl_o,
  input  wire logic scl_oe_n,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  // Resolved wire levels
  output var  logic scl_i,
  output var  logic sda_i
);
  logic scl_last_q = 1'b1;

  always_ff @(posedge clock) begin
    if (!scl_oe_n) begin
      scl_last_q <= scl_o;
    end
  end

  // Released data line floats up to the pull-up
  assign sda_i = sda_oe_n ? 1'b1 : sda_o;
  // Released clock line does not keep its last level
  assign scl_i = scl_oe_n ? ~scl_last_q : scl_o;
endmodule : sep_bus_model
`default_nettype wire

// ---- serial_eeprom_twowire_port_tb.sv ----
// Self-checking bench: firmware-style register writes drive the two-wire bus.
// Assumes sep_top with a short write cycle and sep_bus_model resolving the wires.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_twowire_port_tb;
  import sep_pkg::*;
  localparam int WCYC = 200;
  logic       clock, rst, ce, reg_wr, reg_rd, ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, scl_i, sda_i, ee_busy;
  int         num_errors = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n;

  sep_top #(.WRITE_CYCLES(WCYC)) u_dut (.clock(clock), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ee_scl_o(scl_o), .ee_scl_oe_n(scl_oe_n), .ee_sda_o(sda_o),
    .ee_sda_oe_n(sda_oe_n), .ee_scl_i(scl_i), .ee_sda_i(sda_i), .ee_busy(ee_busy));
  sep_bus_model u_bus (.clock(clock), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl_i(scl_i), .sda_i(sda_i));

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, exp);
  endtask : rd

  // One bus level per register write, held long enough for the synchroniser
  task automatic set(input logic c, input logic d);
    wr(8'h90, {5'h00, c, d, 1'b1});
    repeat (2) @(posedge clock);
  endtask : set

  task automatic start();
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
    set(1'b0, 1'b0);
  endtask : start

  task automatic stop();
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask : stop

  // Byte out MSB first, then a released ninth clock to sample the acknowledge
  task automatic send(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      set(1'b0, b[i]);
      set(1'b1, b[i]);
    end
    set(1'b0, b[0]);
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    a = (sda_i === 1'b0);
    chk({7'h00, sda_o}, 8'h00);
    set(1'b0, 1'b1);
  endtask : send

  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    while (ee_busy !== lvl && cnt < 1000) begin
      @(posedge clock);
      cnt++;
    end
    if (cnt >= 1000) num_errors++;
  endtask : wait_busy

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // ******************************
    // Register access
    // ******************************
    rd(8'h90, 8'h07);
    rd(8'h91, 8'h00);
    wr(8'h90, 8'hFD);
    rd(8'h90, 8'h05);
    chk({7'h00, sda_oe_n}, 8'h00);
    wr(8'h90, 8'h06);
    rd(8'h90, 8'h00);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    wr(8'h90, 8'h03);
    rd(8'h90, 8'h03);
    chk({6'h00, scl_o, scl_oe_n}, 8'h00);
    wr(8'h90, 8'h07);
    // ******************************
    // Byte write, polling, page write
    // ******************************
    start();
    send(8'hA0, ack);
    chk({7'h00, ack}, 8'h01);
    send(8'h13, ack);
    chk({7'h00, ack}, 8'h01);
    send(8'h5A, ack);
    chk({7'h00, ack}, 8'h01);
    stop();
    repeat (8) @(posedge clock);
    chk({7'h00, ee_busy}, 8'h01);
    start();
    send(8'hA0, ack);
    chk({7'h00, ack}, 8'h00);
    stop();
    wait_busy(1'b0, n);
    start();
    send(8'hA0, ack);
    chk({7'h00, ack}, 8'h01);
    send(8'h16, ack);
    for (int k = 0; k < 10; k++) begin
      send(8'h30 + k[7:0], ack);
      chk({7'h00, ack}, 8'h01);
    end
    stop();
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    chk(n[7:0], WCYC[7:0]);
    // ******************************
    // Refused control bytes, power off mid-write
    // ******************************
    start();
    send(8'hB0, ack);
    chk({7'h00, ack}, 8'h00);
    stop();
    start();
    send(8'hA1, ack);
    chk({7'h00, ack}, 8'h00);
    stop();
    start();
    send(8'hA0, ack);
    send(8'h20, ack);
    send(8'h11, ack);
    chk({7'h00, ack}, 8'h01);
    stop();
    repeat (8) @(posedge clock);
    wr(8'h90, 8'h06);
    repeat (3) @(posedge clock);
    chk({7'h00, ee_busy}, 8'h00);
    wr(8'h90, 8'h07);
    rd(8'h90, 8'h07);
    // Clock enable low: a register write must be ignored
    ce <= 1'b0;
    wr(8'h90, 8'h06);
    ce <= 1'b1;
    rd(8'h90, 8'h07);
    wrap_up();
  end
endmodule : serial_eeprom_twowire_port_tb
`default_nettype wire
